// File: rtl/rts_pkg.sv
// Package for the real-time clock rate trim, halt/supply status and alarm block.
// Assumes one 200 MHz system clock and a crystal-tick strobe synchronous to it.
// What this block does
// - Alter one second's tick count every twenty seconds.
// - Low six trim bits zero or one: no correction.
// - Trim code is seven-bit two's complement.
// - Positive codes lengthen seconds, two ticks per step.
// - Negative codes shorten seconds, two ticks per step.
// - Crystal clock output gating ignores trim entirely.
// - Halt and low-supply flags stick until host clears.
// - Setting halt flag forces low-supply flag zero.
// - Halt flag setting clears listed control bits, flags.
// - Power-on sets the oscillation halt flag.
// - Threshold select picks 2.1 V or 1.6 V.
// - Supply sampled in 7.8 ms window each second.
// - No supply sampling while low-supply flag set.
// - Weekly match of day, hour, minute pulls pin low.
// - Daily match of hour and minute pulls pin low.
// - Alarm needs enable; writing zero releases, one ignored.
package rts_pkg;

  // ==========================================================================
  // Timing constants.
  localparam logic [16:0] SEC_TICKS       = 17'h0_8000; // Crystal ticks per second.
  localparam logic [4:0]  TRIM_PERIOD_SEC = 5'h14;      // Seconds per trim interval.
  localparam logic [4:0]  TRIM_SLOT       = 5'h00;      // Second that gets trimmed.
  localparam logic [6:0]  TRIM_SIGN_BASE  = 7'h00;      // 128 minus code, modulo 128.
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          SAMPLE_WIN_NS   = 7_800_000;  // Supply sampling window.
  localparam int          SAMPLE_WIN_CYC  = SAMPLE_WIN_NS / CLK_PERIOD_NS;
  localparam int          WIN_W           = 21;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [6:0] rate_trim_code;        // Signed trim, two's complement.
    logic       weekly_alarm_enable;
    logic       daily_alarm_enable;
    logic       clkout_enable_n_b;
    logic       hour_mode_24;
    logic       test_bit;
    logic [2:0] periodic_select;       // Top bit is periodic_select_hi.
    logic       supply_threshold_select;
    logic       clkout_enable_n_a;
    logic       spare_user_bit;
  } rts_ctrl_t;

  typedef struct packed {
    logic osc_halt_flag;
    logic low_supply_flag;
    logic periodic_irq_flag;
    logic weekly_alarm_flag;
    logic daily_alarm_flag;
  } rts_flags_t;

  typedef struct packed {
    logic [2:0] day_of_week;
    logic [5:0] hour;
    logic [6:0] minute;
  } rts_time_t;

  typedef struct packed {
    logic [6:0] day_mask;
    logic [5:0] hour;
    logic [6:0] minute;
  } rts_walarm_t;

  typedef struct packed {
    logic [5:0] hour;
    logic [6:0] minute;
  } rts_dalarm_t;

  typedef enum logic [1:0] {
    SAMP_IDLE = 2'b01,
    SAMP_OPEN = 2'b10
  } rts_samp_e;

  localparam rts_ctrl_t  CTRL_RESET  = '0;
  localparam rts_flags_t FLAGS_RESET = '{osc_halt_flag: 1'b1, default: 1'b0};

endpackage

// File: rtl/rts_trim_status_alarm.sv
// Top of the rate trim, halt/supply status and alarm block.
// Assumes synchronous inputs, host writes as one-cycle strobes, and that
// the time counters outside consume sec_pulse_o as their seconds advance.
`timescale 1ns/10ps
`default_nettype none
module rts_trim_status_alarm
  import rts_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_WIN_CYC
)
(
  input  wire logic        mclk_i,          // 200 MHz clock.
  input  wire logic        sys_rst_i,       // Sync reset, active high, power-on.
  input  wire logic        ce_i,            // Clock enable, freezes all state.
  input  wire logic        osc_tick_i,      // One pulse per crystal cycle.
  input  wire logic        osc_stop_i,      // Oscillation stop detected.
  input  wire logic        below_2v1_i,     // Supply below 2.1 V comparator.
  input  wire logic        below_1v6_i,     // Supply below 1.6 V comparator.
  input  wire logic        periodic_evt_i,  // Periodic interrupt event.
  input  wire logic        ctrl_wr_i,       // Write strobe for control bits.
  input  wire rts_ctrl_t   ctrl_wdata_i,    // Control write data.
  input  wire logic        flag_wr_i,       // Write strobe for flags.
  input  wire rts_flags_t  flag_wdata_i,    // Zero clears, one ignored.
  input  wire rts_time_t   now_i,           // Current day, hour, minute.
  input  wire rts_walarm_t walarm_i,        // Weekly alarm setting.
  input  wire rts_dalarm_t dalarm_i,        // Daily alarm setting.
  output logic             sec_pulse_o,     // Trimmed one-second pulse.
  output logic             sample_en_o,     // Powers the supply comparator.
  output logic             clkout_gate_o,   // Crystal clock output enabled.
  output rts_ctrl_t        ctrl_o,          // Control bits readback.
  output rts_flags_t       flags_o,         // Flags readback.
  output logic             weekly_alarm_irq_n_o, // Weekly alarm pin.
  output logic             daily_alarm_irq_n_o   // Daily alarm pin.
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [16:0]      tick_cnt;
    logic [4:0]       sec_idx;
    logic             sec_pulse;
    rts_samp_e        samp;
    logic [WIN_W-1:0] win_cnt;
    rts_ctrl_t        ctrl;
    rts_flags_t       flags;
    logic             wk_match_q;
    logic             dy_match_q;
    logic             clk_gate;
    logic             wk_irq_n;
    logic             dy_irq_n;
  } rts_state_t;

  rts_state_t state;
  rts_state_t next_state;

  logic [5:0]  trim_steps;
  logic [16:0] trim_ticks;
  logic [16:0] sec_len;
  logic        trim_off;
  logic        wk_match;
  logic        dy_match;
  logic        below;
  logic        sec_end;
  logic        halt_set;

  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(SAMPLE_CYC - 1);

  // ==========================================================================
  // Trim arithmetic: codes carry a sign in bit 6, steps are two ticks.
  always_comb
  begin
    trim_off = (state.ctrl.rate_trim_code[5:1] == 5'h00);
    if (state.ctrl.rate_trim_code[6])
    begin
      trim_steps = 6'(TRIM_SIGN_BASE - state.ctrl.rate_trim_code);
    end
    else
    begin
      trim_steps = 6'(state.ctrl.rate_trim_code - 7'h01);
    end
    trim_ticks = {10'h000, trim_steps, 1'b0};
    if (trim_off || state.sec_idx != TRIM_SLOT)
    begin
      sec_len = SEC_TICKS;
    end
    else if (state.ctrl.rate_trim_code[6])
    begin
      sec_len = SEC_TICKS - trim_ticks;
    end
    else
    begin
      sec_len = SEC_TICKS + trim_ticks;
    end
  end

  // Match terms; hours and minutes compare as raw counter codes.
  assign wk_match = walarm_i.day_mask[now_i.day_of_week] &&
                    walarm_i.hour == now_i.hour && walarm_i.minute == now_i.minute;
  assign dy_match = dalarm_i.hour == now_i.hour && dalarm_i.minute == now_i.minute;
  // Threshold choice per select bit.
  assign below    = state.ctrl.supply_threshold_select ? below_1v6_i : below_2v1_i;
  assign sec_end  = osc_tick_i && (state.tick_cnt == sec_len - 17'h0_0001);
  assign halt_set = osc_stop_i && !state.flags.osc_halt_flag;

  // ==========================================================================
  // Next-state logic. Hardware sets win over host clears in the same cycle.
  always_comb
  begin
    next_state           = state;
    next_state.sec_pulse = 1'b0;

    // Seconds counter with once-per-interval correction.
    if (osc_tick_i)
    begin
      next_state.tick_cnt = state.tick_cnt + 17'h0_0001;
    end
    if (sec_end)
    begin
      next_state.tick_cnt  = '0;
      next_state.sec_pulse = 1'b1;
      next_state.sec_idx   = (state.sec_idx == TRIM_PERIOD_SEC - 5'h01) ? 5'h00
                                                                       : state.sec_idx + 5'h01;
    end

    // Control writes.
    if (ctrl_wr_i)
    begin
      next_state.ctrl = ctrl_wdata_i;
    end

    // Host clears: a zero clears, a one leaves the flag alone.
    if (flag_wr_i)
    begin
      next_state.flags = state.flags & flag_wdata_i;
    end

    // Supply sampling window, opened at each second, never while flagged.
    unique case (state.samp)
      SAMP_IDLE:
      begin
        if (state.sec_pulse && !state.flags.low_supply_flag)
        begin
          next_state.samp    = SAMP_OPEN;
          next_state.win_cnt = '0;
        end
      end
      SAMP_OPEN:
      begin
        next_state.win_cnt = state.win_cnt + WIN_W'(1);
        if (below)
        begin
          next_state.flags.low_supply_flag = 1'b1;
        end
        if (below || state.flags.low_supply_flag || state.win_cnt == WIN_LAST)
        begin
          next_state.samp = SAMP_IDLE;
        end
      end
    endcase

    // Event flags.
    if (periodic_evt_i)
    begin
      next_state.flags.periodic_irq_flag = 1'b1;
    end
    next_state.wk_match_q = wk_match;
    next_state.dy_match_q = dy_match;
    if (wk_match && !state.wk_match_q && state.ctrl.weekly_alarm_enable)
    begin
      next_state.flags.weekly_alarm_flag = 1'b1;
    end
    if (dy_match && !state.dy_match_q && state.ctrl.daily_alarm_enable)
    begin
      next_state.flags.daily_alarm_flag = 1'b1;
    end

    // Oscillation halt: sets the flag and wipes configuration at that moment.
    if (osc_stop_i)
    begin
      next_state.flags.osc_halt_flag = 1'b1;
    end
    if (halt_set)
    begin
      next_state.ctrl  = CTRL_RESET;
      next_state.flags = FLAGS_RESET;
      next_state.samp  = SAMP_IDLE;
    end
    // A low-supply reading means nothing once the oscillator has halted.
    if (next_state.flags.osc_halt_flag)
    begin
      next_state.flags.low_supply_flag = 1'b0;
    end

    // Pins follow the next flags so they match the flag readback.
    next_state.wk_irq_n = !(next_state.flags.weekly_alarm_flag &&
                            next_state.ctrl.weekly_alarm_enable);
    next_state.dy_irq_n = !(next_state.flags.daily_alarm_flag &&
                            next_state.ctrl.daily_alarm_enable);
    // The crystal output gate never looks at the trim code.
    next_state.clk_gate = !next_state.ctrl.clkout_enable_n_a ||
                          !next_state.ctrl.clkout_enable_n_b;
  end

  // ==========================================================================
  // Registers; reset models power-up from zero volts.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state          <= '0;
      state.samp     <= SAMP_IDLE;
      state.flags    <= FLAGS_RESET;
      state.wk_irq_n <= 1'b1;
      state.dy_irq_n <= 1'b1;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops.
  assign sec_pulse_o          = state.sec_pulse;
  assign sample_en_o          = (state.samp == SAMP_OPEN);
  assign clkout_gate_o        = state.clk_gate;
  assign ctrl_o               = state.ctrl;
  assign flags_o              = state.flags;
  assign weekly_alarm_irq_n_o = state.wk_irq_n;
  assign daily_alarm_irq_n_o  = state.dy_irq_n;

  // ==========================================================================
  // Checks.
  trim_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    trim_off |-> sec_len == SEC_TICKS) else $error("trim applied for a null code");

  trim_slot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state.sec_idx != TRIM_SLOT |-> sec_len == SEC_TICKS && state.sec_idx < TRIM_PERIOD_SEC)
    else $error("trim outside its slot");

  halt_clears_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && halt_set |=> state.ctrl == CTRL_RESET && state.flags.osc_halt_flag)
    else $error("halt did not clear control bits");

  halt_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state.flags.osc_halt_flag |-> !state.flags.low_supply_flag)
    else $error("low-supply flag set under halt");

  low_sticky_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state.flags.low_supply_flag && !osc_stop_i && !(flag_wr_i && !flag_wdata_i.low_supply_flag)
    |=> state.flags.low_supply_flag) else $error("low-supply flag lost");

  no_sample_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state.flags.low_supply_flag ##1 state.flags.low_supply_flag |-> !sample_en_o)
    else $error("sampling while low-supply flag set");

  low_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(state.flags.low_supply_flag) |-> $past(sample_en_o) &&
      ($past(state.ctrl.supply_threshold_select) ? $past(below_1v6_i) : $past(below_2v1_i)))
    else $error("low-supply flag without sampled drop");

  wk_pin_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !weekly_alarm_irq_n_o |-> state.flags.weekly_alarm_flag && state.ctrl.weekly_alarm_enable)
    else $error("weekly pin low without flag and enable");

  dy_one_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && flag_wr_i && !state.flags.daily_alarm_flag && !dy_match && !periodic_evt_i
    |=> !state.flags.daily_alarm_flag) else $error("writing a flag set it");

  por_halt_a: assert property (@(posedge mclk_i)
    $fell(sys_rst_i) |-> state.flags.osc_halt_flag) else $error("power-on halt flag missing");

endmodule
`default_nettype wire

// File: tb/rts_host_model.sv
// Host model: writes control words and flag clears as one-cycle strobes.
// Assumes callers enter its tasks between falling edges of mclk_i.
`timescale 1ns/10ps
`default_nettype none
module rts_host_model
  import rts_pkg::*;
(
  input  wire logic  mclk_i,    // Block clock.
  output logic       ctrl_wr_o, // Control write strobe.
  output rts_ctrl_t  ctrl_wd_o, // Control write data.
  output logic       flag_wr_o, // Flag write strobe.
  output rts_flags_t flag_wd_o  // Flag write data.
);
  // ==========================================================================
  // Idle data is inverted so a stale word never passes for a real write.
  initial
  begin
    ctrl_wr_o = 1'b0;
    ctrl_wd_o = '1;
    flag_wr_o = 1'b0;
    flag_wd_o = '1;
  end

  // Strobe and data held across exactly one rising edge.
  task automatic wr_ctrl(input rts_ctrl_t d);
  begin
    @(negedge mclk_i);
    ctrl_wr_o = 1'b1;
    ctrl_wd_o = d;
    @(negedge mclk_i);
    ctrl_wr_o = 1'b0;
    ctrl_wd_o = ~d;
  end
  endtask

  // Zero bits clear flags; the bench clears the halt flag after reset.
  task automatic wr_flags(input rts_flags_t d);
  begin
    @(negedge mclk_i);
    flag_wr_o = 1'b1;
    flag_wd_o = d;
    @(negedge mclk_i);
    flag_wr_o = 1'b0;
    flag_wd_o = ~d;
  end
  endtask
endmodule
`default_nettype wire

// File: tb/rts_trim_status_alarm_test.sv
// Self-checking bench for the trim, status and alarm block.
// Assumes a crystal tick on nearly every clock cycle and a 20-cycle sampling window.
`timescale 1ns/10ps
`default_nettype none
module rts_trim_status_alarm_test
  import rts_pkg::*;
;
  logic        mclk_i;
  logic        sys_rst_i;
  logic        ce_i;
  logic        osc_tick_i;
  logic        osc_stop_i;
  logic        below_2v1_i;
  logic        below_1v6_i;
  logic        periodic_evt_i;
  logic        ctrl_wr_i;
  logic        flag_wr_i;
  logic        sec_pulse_o;
  logic        sample_en_o;
  logic        clkout_gate_o;
  logic        wk_n;
  logic        dy_n;
  rts_ctrl_t   ctrl_wdata_i;
  rts_ctrl_t   ctrl_o;
  rts_ctrl_t   c;
  rts_flags_t  flag_wdata_i;
  rts_flags_t  flags_o;
  rts_time_t   now_i;
  rts_walarm_t walarm_i;
  rts_dalarm_t dalarm_i;
  int          n_fail;
  int          checks_done;
  int          cyc;
  int          rel;
  int          n;

  rts_trim_status_alarm #(.SAMPLE_CYC(20)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .osc_tick_i(osc_tick_i), .osc_stop_i(osc_stop_i), .below_2v1_i(below_2v1_i),
    .below_1v6_i(below_1v6_i), .periodic_evt_i(periodic_evt_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .flag_wr_i(flag_wr_i), .flag_wdata_i(flag_wdata_i),
    .now_i(now_i), .walarm_i(walarm_i), .dalarm_i(dalarm_i), .sec_pulse_o(sec_pulse_o),
    .sample_en_o(sample_en_o), .clkout_gate_o(clkout_gate_o), .ctrl_o(ctrl_o),
    .flags_o(flags_o), .weekly_alarm_irq_n_o(wk_n), .daily_alarm_irq_n_o(dy_n));

  rts_host_model host (.mclk_i(mclk_i), .ctrl_wr_o(ctrl_wr_i), .ctrl_wd_o(ctrl_wdata_i),
    .flag_wr_o(flag_wr_i), .flag_wd_o(flag_wdata_i));

  // ==========================================================================
  // Clock and cycle ceiling; three full seconds need about 98,500 cycles.
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 100000)
    begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  end
  endtask

  task automatic summarize();
  begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // Reset, clear the halt flag, program the control word.
  task automatic start(input rts_ctrl_t w);
  begin
    @(negedge mclk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    rel = cyc;
    host.wr_flags('0);
    host.wr_ctrl(w);
  end
  endtask

  // Edges from reset release until the first trimmed second ends.
  task automatic sec_len(input int exp);
  begin
    while (sec_pulse_o !== 1'b1 && cyc - rel < 40000)
      @(negedge mclk_i);
    check("sec_len", cyc - rel, exp);
  end
  endtask

  task automatic step();
  begin
    @(negedge mclk_i);
  end
  endtask

  // ==========================================================================
  // Main sequence.
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    osc_stop_i = 1'b0;
    below_2v1_i = 1'b1;
    below_1v6_i = 1'b0;
    periodic_evt_i = 1'b0;
    ce_i = 1'b1;
    osc_tick_i = 1'b1;
    now_i = '0;
    // Alarm settings start off the test time and are moved onto it later.
    walarm_i = '{day_mask: 7'h00, hour: 6'h12, minute: 7'h30};
    dalarm_i = '{hour: 6'h12, minute: 7'h31};
    // Maximum slowdown with the low threshold: the 2.1 V result is ignored.
    c = '0;
    c.rate_trim_code = 7'h3F;
    c.supply_threshold_select = 1'b1;
    c.clkout_enable_n_b = 1'b1;
    start(c);
    check("gate", clkout_gate_o, 1'b1);
    check("ctrl", ctrl_o, c);
    sec_len(32768 + 124);
    step();
    check("win_open", sample_en_o, 1'b1);
    n = 0;
    while (sample_en_o === 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    check("win_len", n, 20);
    check("low_sup", flags_o.low_supply_flag, 1'b0);
    // Maximum speedup with the default threshold and a low supply.
    c.rate_trim_code = 7'h42;
    c.supply_threshold_select = 1'b0;
    c.weekly_alarm_enable = 1'b1;
    c.daily_alarm_enable = 1'b1;
    start(c);
    sec_len(32768 - 124);
    step();
    step();
    check("low_set", {flags_o.low_supply_flag, sample_en_o}, 2'b10);
    below_2v1_i = 1'b0;
    step();
    check("low_stick", flags_o.low_supply_flag, 1'b1);
    // Alarms: both match, clear one, ignore ones, then a disabled match.
    walarm_i.day_mask = 7'h08;
    dalarm_i.minute = 7'h30;
    now_i = '{day_of_week: 3'h3, hour: 6'h12, minute: 7'h30};
    step();
    check("irq_both", {wk_n, dy_n}, 2'b00);
    host.wr_flags(5'b11101);
    check("irq_wclr", {wk_n, dy_n}, 2'b10);
    host.wr_flags(5'b11111);
    check("flag_ones", flags_o, 5'b01001);
    c.daily_alarm_enable = 1'b0;
    host.wr_ctrl(c);
    host.wr_flags(5'b11110);
    now_i.minute = 7'h31;
    step();
    now_i.minute = 7'h30;
    step();
    check("irq_dis", {wk_n, dy_n}, 2'b01);
    // Halt set clears control bits and every other flag at once.
    periodic_evt_i = 1'b1;
    step();
    periodic_evt_i = 1'b0;
    check("periodic", flags_o.periodic_irq_flag, 1'b1);
    osc_stop_i = 1'b1;
    step();
    osc_stop_i = 1'b0;
    step();
    check("halt_flags", flags_o, 5'h10);
    check("halt_ctrl", ctrl_o, 0);
    check("halt_pins", {wk_n, dy_n}, 2'b11);
    host.wr_flags('0);
    check("halt_clr", flags_o, 5'h00);
    // A code of -63 leaves the second untouched; both clock gates off.
    c = '0;
    c.rate_trim_code = 7'h41;
    c.clkout_enable_n_a = 1'b1;
    c.clkout_enable_n_b = 1'b1;
    start(c);
    check("gate_off", clkout_gate_o, 1'b0);
    // Ten frozen cycles and six missing ticks stretch the second in clock cycles.
    ce_i = 1'b0;
    periodic_evt_i = 1'b1;
    repeat (10) step();
    check("frozen", flags_o, 5'h00);
    ce_i = 1'b1;
    periodic_evt_i = 1'b0;
    osc_tick_i = 1'b0;
    repeat (6) step();
    osc_tick_i = 1'b1;
    // The 1.6 V comparator alone must not flag while the 2.1 V level is selected.
    below_1v6_i = 1'b1;
    sec_len(32768 + 16);
    step();
    step();
    check("low_sel", {flags_o.low_supply_flag, sample_en_o}, 2'b01);
    summarize();
  end
endmodule
`default_nettype wire
